// ---- cofle_pkg.sv ----
// Shared constants and types for the card write / format load executor.
// Assumes a 125 MHz core clock and binary word addresses.
package cofle_pkg;

  // Clock rate and instruction timing
  localparam int CLK_MHZ     = 125;
  localparam int FETCH_US    = 90;
  localparam int EXEC_MIN_US = 8545;
  localparam int EXEC_MAX_US = 11940;
  localparam int FETCH_CYC   = FETCH_US * CLK_MHZ;
  localparam int EXEC_MIN_CYC = EXEC_MIN_US * CLK_MHZ;
  localparam int EXEC_MAX_CYC = EXEC_MAX_US * CLK_MHZ;
  localparam int TMR_W       = 21;

  // Storage and transfer geometry
  localparam int MEM_WORDS   = 4000;
  localparam int ADDR_W      = 16;
  localparam int WORD_DIGITS = 11;
  localparam int XFER_WORDS  = 29;
  localparam int CW_LAST_DIG = 9;  // Digits 2..10 of the last word
  localparam int FL_LAST_DIG = 7;  // Positions 309..315
  localparam int NUM_UNITS   = 10;

  // Operation codes (two decimal digits)
  localparam logic [7:0] OP_CARD_WRITE = 8'h61;
  localparam logic [7:0] OP_FMT_LOAD   = 8'h62;

  // Editing control stream codes presented by the buffer
  localparam logic [1:0] EC_SKIP  = 2'h0;
  localparam logic [1:0] EC_DIG   = 2'h1;
  localparam logic [1:0] EC_SIGN  = 2'h2;  // Pair 10
  localparam logic [1:0] EC_MERGE = 2'h3;  // Pair 11

  localparam logic [3:0] DIGIT_MAX  = 4'h9;
  localparam logic [3:0] FMT_BITS   = 4'h3;  // Two bits per band position
  localparam logic [2:0] BAND_FIRST = 3'h1;

  // Instruction word: sign, unit, unused, control, format, op, address
  typedef struct packed {
    logic [3:0]        sgn;
    logic [3:0]        unit;
    logic [3:0]        spare;
    logic [3:0]        ctl;
    logic [3:0]        fmt;
    logic [7:0]        op;
    logic [ADDR_W-1:0] addr;
  } cofle_instr_t;

  typedef enum logic [1:0] {
    ZN_NONE = 2'h0,
    ZN_11   = 2'h1,
    ZN_12   = 2'h2
  } cofle_zone_t;

  // One column or band position toward the buffer
  typedef struct packed {
    cofle_zone_t zone;
    logic        blank;
    logic [3:0]  num;
  } cofle_col_t;

  typedef struct packed {
    logic tmo;
    logic digit;
    logic unit;
    logic addr;
  } cofle_alarm_t;

endpackage

// ---- cofle_exec.sv ----
// Execution sequencer for card write and format load instructions.
// Assumes storage answers a read one cycle after the strobe, and that the
// buffer pins (step, edit code, part-one end, last row, unit present) are
// asynchronous to the core clock.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

module cofle_exec #(
  parameter int FETCH_CYC    = cofle_pkg::FETCH_CYC,
  parameter int EXEC_MIN_CYC = cofle_pkg::EXEC_MIN_CYC,
  parameter int EXEC_MAX_CYC = cofle_pkg::EXEC_MAX_CYC,
  parameter int MEM_WORDS    = cofle_pkg::MEM_WORDS
) (
  input  wire logic                          MCLK_IN,
  input  wire logic                          RST_IN,
  input  wire logic                          START_IN,
  input  wire cofle_pkg::cofle_instr_t       INSTR_IN,
  input  wire logic [cofle_pkg::ADDR_W-1:0]  INDEX_IN,
  input  wire logic                          ALARM_CLR_IN,
  output logic                               MEM_RD_OUT,
  output logic [cofle_pkg::ADDR_W-1:0]       MEM_ADDR_OUT,
  input  wire logic [43:0]                   MEM_DATA_IN,
  input  wire logic                          BUF_STEP_IN,
  input  wire logic [1:0]                    BUF_EDIT_IN,
  input  wire logic                          BUF_P1_DONE_IN,
  input  wire logic                          BUF_LAST_ROW_IN,
  input  wire logic [cofle_pkg::NUM_UNITS-1:0] UNIT_PRESENT_IN,
  output cofle_pkg::cofle_col_t              BUF_COL_OUT,
  output logic                               BUF_COL_VLD_OUT,
  output logic [3:0]                         BUF_UNIT_OUT,
  output logic [2:0]                         BUF_BAND_OUT,
  output logic                               BUF_FMT_LOAD_OUT,
  output logic                               SUPPRESS_OUT,
  output logic                               LOCKOUT_OUT,
  output logic [4:0]                         RELAY_OUT,
  output logic                               SEND_OUT,
  output logic                               BUSY_OUT,
  output logic                               DONE_OUT,
  output cofle_pkg::cofle_alarm_t            ALARM_OUT
);

  localparam int SW = cofle_pkg::NUM_UNITS + 5;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_FETCH  = 4'h1,
    ST_CHECK  = 4'h2,
    ST_LOAD   = 4'h3,
    ST_RD     = 4'h4,
    ST_CAP    = 4'h5,
    ST_XFER   = 4'h6,
    ST_POST   = 4'h7,
    ST_FINISH = 4'h8,
    ST_ALARM  = 4'h9
  } cofle_state_t;

  cofle_state_t                   state_q;
  cofle_pkg::cofle_instr_t        instr_q;
  logic [SW-1:0]                  sync1_q, sync2_q;
  logic                           step_prev_q, p1_prev_q;
  logic [cofle_pkg::TMR_W-1:0]    tmr_q;
  logic [cofle_pkg::ADDR_W-1:0]   e_q;
  logic [4:0]                     wleft_q;
  logic [3:0]                     dcnt_q;
  logic [43:0]                    data_q;
  logic                           blk_q;
  cofle_pkg::cofle_alarm_t        pend_q;
  logic                           is_cw;
  logic                           step_ev, p1_ev, last_row;
  logic [1:0]                     edit;
  logic [cofle_pkg::NUM_UNITS-1:0] present;
  logic [cofle_pkg::ADDR_W-1:0]   base_c;
  cofle_pkg::cofle_col_t          col_c;
  logic [1:0]                     take_c;
  logic                           bad_c;
  logic [3:0]                     lo_d, nx_d;
  cofle_pkg::cofle_zone_t         zone_c;

  // Two-stage synchroniser for every buffer-side pin
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {BUF_STEP_IN, BUF_P1_DONE_IN, BUF_LAST_ROW_IN, BUF_EDIT_IN, UNIT_PRESENT_IN};
      sync2_q <= sync1_q;
    end
  end

  // Edge detectors on the synchronised buffer clock and part-one end
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      step_prev_q <= 1'b0;
      p1_prev_q   <= 1'b0;
    end else begin
      step_prev_q <= sync2_q[SW-1];
      p1_prev_q   <= sync2_q[SW-2];
    end
  end

  assign step_ev  = sync2_q[SW-1] & ~step_prev_q;
  assign p1_ev    = sync2_q[SW-2] & ~p1_prev_q;
  assign last_row = sync2_q[SW-3];
  assign edit     = sync2_q[SW-4:SW-5];
  assign present  = sync2_q[cofle_pkg::NUM_UNITS-1:0];
  assign is_cw    = (instr_q.op == cofle_pkg::OP_CARD_WRITE);
  assign lo_d     = data_q[3:0];
  assign nx_d     = data_q[7:4];
  // Index modification of the base address
  assign base_c   = instr_q.sgn[0] ? cofle_pkg::ADDR_W'(instr_q.addr + INDEX_IN) : instr_q.addr;

  // Sign zone: 1 always punches 11, 0 punches 12 unless suppressed
  always_comb begin
    if (nx_d[0] && edit == cofle_pkg::EC_MERGE) begin
      zone_c = cofle_pkg::ZN_11;
    end else if (lo_d[0] && edit == cofle_pkg::EC_SIGN) begin
      zone_c = cofle_pkg::ZN_11;
    end else if (SUPPRESS_OUT) begin
      zone_c = cofle_pkg::ZN_NONE;
    end else begin
      zone_c = cofle_pkg::ZN_12;
    end
  end

  // Column edit for one buffer step
  always_comb begin
    col_c  = '{zone: cofle_pkg::ZN_NONE, blank: 1'b0, num: lo_d};
    take_c = 2'h1;
    bad_c  = (lo_d > cofle_pkg::DIGIT_MAX);
    if (!is_cw) begin
      col_c.num = lo_d & cofle_pkg::FMT_BITS;
    end else begin
      case (edit)
        cofle_pkg::EC_SKIP: begin
          col_c.blank = 1'b1;
          take_c      = 2'h0;
          bad_c       = 1'b0;
        end
        cofle_pkg::EC_SIGN: begin
          col_c.zone  = zone_c;
          col_c.blank = 1'b1;
        end
        cofle_pkg::EC_MERGE: begin
          col_c.zone = zone_c;
          take_c     = (dcnt_q > 4'h1) ? 2'h2 : 2'h1;
          bad_c      = bad_c | ((dcnt_q > 4'h1) && (nx_d > cofle_pkg::DIGIT_MAX));
        end
        default: begin
          take_c = 2'h1;
        end
      endcase
    end
  end

  // Instruction sequencing, address counter and digit shifting
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_q         <= ST_IDLE;
      instr_q         <= '0;
      tmr_q           <= '0;
      e_q             <= '0;
      wleft_q         <= '0;
      dcnt_q          <= '0;
      data_q          <= '0;
      blk_q           <= 1'b0;
      pend_q          <= '0;
      ALARM_OUT       <= '0;
      MEM_RD_OUT      <= 1'b0;
      MEM_ADDR_OUT    <= '0;
      BUF_COL_OUT     <= '0;
      BUF_COL_VLD_OUT <= 1'b0;
      SEND_OUT        <= 1'b0;
      DONE_OUT        <= 1'b0;
    end else begin
      MEM_RD_OUT      <= 1'b0;
      BUF_COL_VLD_OUT <= 1'b0;
      SEND_OUT        <= 1'b0;
      DONE_OUT        <= 1'b0;
      tmr_q           <= tmr_q + 1'b1;
      case (state_q)
        ST_IDLE: begin
          tmr_q <= '0;
          if (START_IN && (INSTR_IN.op == cofle_pkg::OP_CARD_WRITE ||
                           INSTR_IN.op == cofle_pkg::OP_FMT_LOAD)) begin
            instr_q <= INSTR_IN;
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (tmr_q == cofle_pkg::TMR_W'(FETCH_CYC - 1)) begin
            tmr_q   <= '0;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          e_q     <= base_c;
          wleft_q <= 5'(cofle_pkg::XFER_WORDS);
          blk_q   <= 1'b0;
          pend_q  <= '0;
          if (instr_q.unit > 4'(cofle_pkg::NUM_UNITS - 1) || !present[instr_q.unit]) begin
            ALARM_OUT.unit <= 1'b1;
            state_q        <= ST_ALARM;
          end else begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (e_q >= cofle_pkg::ADDR_W'(MEM_WORDS)) begin
            pend_q.addr <= 1'b1;
            blk_q       <= 1'b1;
            state_q     <= ST_XFER;
          end else begin
            MEM_RD_OUT   <= 1'b1;
            MEM_ADDR_OUT <= e_q;
            state_q      <= ST_RD;
          end
        end
        ST_RD: begin
          state_q <= ST_CAP;
        end
        ST_CAP: begin
          wleft_q <= wleft_q - 1'b1;
          // Decrement modulo installed storage
          e_q <= (e_q == '0) ? cofle_pkg::ADDR_W'(MEM_WORDS - 1) : e_q - 1'b1;
          if (wleft_q == 5'h1 && is_cw) begin
            data_q <= MEM_DATA_IN >> (4 * (cofle_pkg::WORD_DIGITS - cofle_pkg::CW_LAST_DIG));
            dcnt_q <= 4'(cofle_pkg::CW_LAST_DIG);
          end else if (wleft_q == 5'h1) begin
            data_q <= MEM_DATA_IN >> (4 * (cofle_pkg::WORD_DIGITS - cofle_pkg::FL_LAST_DIG));
            dcnt_q <= 4'(cofle_pkg::FL_LAST_DIG);
          end else begin
            data_q <= MEM_DATA_IN;
            dcnt_q <= 4'(cofle_pkg::WORD_DIGITS);
          end
          state_q <= ST_XFER;
        end
        ST_XFER: begin
          if (tmr_q >= cofle_pkg::TMR_W'(EXEC_MAX_CYC - 1)) begin
            ALARM_OUT.tmo <= 1'b1;
            state_q       <= ST_ALARM;
          end else if (p1_ev) begin
            state_q <= ST_POST;
          end else if (!blk_q && dcnt_q == 4'h0) begin
            if (wleft_q == 5'h0) begin
              blk_q <= 1'b1;
            end else begin
              state_q <= ST_LOAD;
            end
          end else if (!blk_q && step_ev) begin
            if (bad_c) begin
              pend_q.digit <= 1'b1;
              blk_q        <= 1'b1;
            end else begin
              BUF_COL_OUT     <= col_c;
              BUF_COL_VLD_OUT <= 1'b1;
              dcnt_q          <= dcnt_q - 4'(take_c);
              data_q          <= data_q >> (4 * take_c);
            end
          end
        end
        ST_POST: begin
          SEND_OUT <= is_cw;
          if (pend_q != '0) begin
            ALARM_OUT <= pend_q;
            state_q   <= ST_ALARM;
          end else begin
            state_q <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          if (tmr_q >= cofle_pkg::TMR_W'(EXEC_MIN_CYC - 1)) begin
            DONE_OUT <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        ST_ALARM: begin
          tmr_q <= '0;
          if (ALARM_CLR_IN) begin
            ALARM_OUT <= '0;
            state_q   <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Unit, band, suppression and lockout selection from the instruction
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      BUF_UNIT_OUT     <= '0;
      BUF_BAND_OUT     <= cofle_pkg::BAND_FIRST;
      BUF_FMT_LOAD_OUT <= 1'b0;
      SUPPRESS_OUT     <= 1'b0;
      LOCKOUT_OUT      <= 1'b0;
      BUSY_OUT         <= 1'b0;
    end else begin
      BUSY_OUT <= (state_q != ST_IDLE) && (state_q != ST_ALARM);
      if (state_q == ST_CHECK) begin
        BUF_UNIT_OUT     <= instr_q.unit;
        BUF_BAND_OUT     <= 3'(instr_q.fmt[3:1] + cofle_pkg::BAND_FIRST);
        BUF_FMT_LOAD_OUT <= !is_cw;
        SUPPRESS_OUT     <= is_cw && !instr_q.fmt[0];
        if (!is_cw) begin
          LOCKOUT_OUT <= instr_q.fmt[0];
        end
      end
    end
  end

  // Printer control relays, held until the last row leaves
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      RELAY_OUT <= '0;
    end else if (state_q == ST_CHECK && is_cw) begin
      case (instr_q.ctl)
        4'h1:    RELAY_OUT <= 5'h01;
        4'h2:    RELAY_OUT <= 5'h02;
        4'h3:    RELAY_OUT <= 5'h04;
        4'h4:    RELAY_OUT <= 5'h08;
        4'h5:    RELAY_OUT <= 5'h10;
        4'h6:    RELAY_OUT <= 5'h0a;
        4'h7:    RELAY_OUT <= 5'h14;
        4'h9:    RELAY_OUT <= 5'h01;
        default: RELAY_OUT <= 5'h00;
      endcase
    end else if (last_row) begin
      RELAY_OUT <= '0;
    end
  end

endmodule

// ---- cofle_exec_props.sv ----
// Port assertions for the card write / format load executor.
// Bound to cofle_exec; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module cofle_exec_props #(
  parameter int FETCH_CYC    = 20,
  parameter int EXEC_MIN_CYC = 200,
  parameter int MEM_WORDS    = 4000
) (
  input wire logic                    MCLK_IN,
  input wire logic                    RST_IN,
  input wire logic                    START_IN,
  input wire logic                    ALARM_CLR_IN,
  input wire logic                    BUF_LAST_ROW_IN,
  input wire logic                    MEM_RD_OUT,
  input wire logic [15:0]             MEM_ADDR_OUT,
  input wire cofle_pkg::cofle_col_t   BUF_COL_OUT,
  input wire logic                    BUF_COL_VLD_OUT,
  input wire logic [2:0]              BUF_BAND_OUT,
  input wire logic                    BUF_FMT_LOAD_OUT,
  input wire logic                    SUPPRESS_OUT,
  input wire logic [4:0]              RELAY_OUT,
  input wire logic                    SEND_OUT,
  input wire logic                    BUSY_OUT,
  input wire logic                    DONE_OUT,
  input wire cofle_pkg::cofle_alarm_t ALARM_OUT
);
  logic [15:0] last_q;
  logic        seen_q;
  int          busy_q;

  default clocking @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);

  // Last read address and busy time of the running instruction
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || START_IN) begin
      last_q <= 16'h0;
      seen_q <= 1'b0;
      busy_q <= 0;
    end else begin
      if (MEM_RD_OUT) begin
        last_q <= MEM_ADDR_OUT;
        seen_q <= 1'b1;
      end
      if (BUSY_OUT) begin
        busy_q <= busy_q + 1;
      end
    end
  end

  chk_addr_step: assert property (
    MEM_RD_OUT && seen_q |-> MEM_ADDR_OUT == ((last_q == 16'h0) ? 16'(MEM_WORDS - 1) : last_q - 16'h1))
    else $error("read address did not step down by one");
  chk_addr_exists: assert property (
    MEM_RD_OUT |-> MEM_ADDR_OUT < 16'(MEM_WORDS))
    else $error("read of a missing address");
  chk_relay_drop: assert property (
    $rose(BUF_LAST_ROW_IN) |-> ##[1:6] RELAY_OUT == 5'h0)
    else $error("relays not released at last row");
  chk_no_zone12: assert property (
    BUF_COL_VLD_OUT && SUPPRESS_OUT && !BUF_FMT_LOAD_OUT |-> BUF_COL_OUT.zone != cofle_pkg::ZN_12)
    else $error("zone 12 while suppressed");
  chk_two_bits: assert property (
    BUF_COL_VLD_OUT && BUF_FMT_LOAD_OUT |-> BUF_COL_OUT.num <= 4'h3)
    else $error("format position wider than two bits");
  chk_band_range: assert property (
    BUSY_OUT |-> BUF_BAND_OUT inside {[3'h1:3'h5]})
    else $error("band out of range");
  chk_alarm_hold: assert property (
    ALARM_OUT != 4'h0 && !ALARM_CLR_IN |=> $stable(ALARM_OUT))
    else $error("alarm changed without clear");
  chk_alarm_idle: assert property (
    ALARM_OUT != 4'h0 |=> !BUSY_OUT && !MEM_RD_OUT && !BUF_COL_VLD_OUT)
    else $error("activity during alarm stop");
  chk_exec_time: assert property (
    DONE_OUT |-> busy_q >= FETCH_CYC + EXEC_MIN_CYC - 2)
    else $error("instruction finished too early");
  chk_send_cw: assert property (
    SEND_OUT |-> !BUF_FMT_LOAD_OUT)
    else $error("send started for a format load");

  cov_done: cover property (DONE_OUT);
  cov_addr_alarm: cover property (ALARM_OUT.addr);
  cov_digit_alarm: cover property (ALARM_OUT.digit);
endmodule

bind cofle_exec cofle_exec_props #(
  .FETCH_CYC(FETCH_CYC), .EXEC_MIN_CYC(EXEC_MIN_CYC), .MEM_WORDS(MEM_WORDS)
) u_props (
  .MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .START_IN(START_IN), .ALARM_CLR_IN(ALARM_CLR_IN),
  .BUF_LAST_ROW_IN(BUF_LAST_ROW_IN), .MEM_RD_OUT(MEM_RD_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
  .BUF_COL_OUT(BUF_COL_OUT), .BUF_COL_VLD_OUT(BUF_COL_VLD_OUT), .BUF_BAND_OUT(BUF_BAND_OUT),
  .BUF_FMT_LOAD_OUT(BUF_FMT_LOAD_OUT), .SUPPRESS_OUT(SUPPRESS_OUT), .RELAY_OUT(RELAY_OUT),
  .SEND_OUT(SEND_OUT), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .ALARM_OUT(ALARM_OUT)
);

// ---- cofle_buf_model.sv ----
// Card buffer unit model: paces the executor with step pulses.
// Assumes the bench sets edits, n_steps and gap before each start.
`timescale 1ns/100ps
module cofle_buf_model (
  input  wire logic                  clk_in,
  input  wire logic                  busy_in,
  input  wire logic                  col_vld_in,
  input  wire cofle_pkg::cofle_col_t col_in,
  output logic                       step_out,
  output logic [1:0]                 edit_out,
  output logic                       p1_done_out,
  output logic                       last_row_out
);
  logic [1:0]            edits [0:511];
  int                    n_steps = 0;
  int                    gap = 30;
  logic                  active = 1'b0;
  cofle_pkg::cofle_col_t cols [$];

  // Keep every column handed over
  always @(posedge clk_in) begin
    if (col_vld_in) begin
      cols.push_back(col_in);
    end
  end

  // One buffer cycle: part one steps, then part two with the last row
  initial begin
    step_out = 1'b0;
    edit_out = 2'h0;
    p1_done_out = 1'b0;
    last_row_out = 1'b0;
    forever begin
      @(posedge busy_in);
      active = 1'b1;
      repeat (gap) @(posedge clk_in);
      for (int k = 0; k < n_steps; k++) begin
        edit_out <= edits[k]; // Settles a cycle before the step
        @(posedge clk_in);
        step_out <= 1'b1;
        repeat (5) @(posedge clk_in);
        step_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        edit_out <= ~edits[k]; // Released code does not keep its value
        repeat (2) @(posedge clk_in);
      end
      p1_done_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      p1_done_out <= 1'b0;
      repeat (40) @(posedge clk_in);
      last_row_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      last_row_out <= 1'b0;
      @(posedge clk_in);
      active = 1'b0;
    end
  end
endmodule

// ---- cofle_exec_test.sv ----
// Self-checking bench for cofle_exec with a buffer model and storage.
// Assumes shortened fetch and execute counts; storage is modelled here.
`timescale 1ns/100ps
module cofle_exec_test;
  localparam int FETCH = 20;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    start = 1'b0;
  logic                    clr = 1'b0;
  logic [15:0]             index = 16'h3;
  logic [15:0]             bad_a = 16'hffff;
  logic [9:0]              present = 10'h3ff;
  cofle_pkg::cofle_instr_t instr = '0;
  cofle_pkg::cofle_col_t   col;
  cofle_pkg::cofle_alarm_t alarm;
  logic [15:0]             maddr, eb;
  logic [43:0]             mdata;
  logic [3:0]              unit;
  logic [2:0]              band;
  logic [4:0]              relay;
  logic [1:0]              edit;
  logic                    rd, step, p1, lastrow, vld, fl, sup, lock, send, busy, done, tail, mixed;
  logic [15:0]             reads [$];
  int                      n_send, seed, cycles, miscompares, n_tests;

  always #4 clk = ~clk;

  cofle_exec #(.FETCH_CYC(FETCH), .EXEC_MIN_CYC(200), .EXEC_MAX_CYC(20000), .MEM_WORDS(4000)) i_dut (
    .MCLK_IN(clk), .RST_IN(rst), .START_IN(start), .INSTR_IN(instr), .INDEX_IN(index),
    .ALARM_CLR_IN(clr), .MEM_RD_OUT(rd), .MEM_ADDR_OUT(maddr), .MEM_DATA_IN(mdata),
    .BUF_STEP_IN(step), .BUF_EDIT_IN(edit), .BUF_P1_DONE_IN(p1), .BUF_LAST_ROW_IN(lastrow),
    .UNIT_PRESENT_IN(present), .BUF_COL_OUT(col), .BUF_COL_VLD_OUT(vld), .BUF_UNIT_OUT(unit),
    .BUF_BAND_OUT(band), .BUF_FMT_LOAD_OUT(fl), .SUPPRESS_OUT(sup), .LOCKOUT_OUT(lock),
    .RELAY_OUT(relay), .SEND_OUT(send), .BUSY_OUT(busy), .DONE_OUT(done), .ALARM_OUT(alarm));
  cofle_buf_model i_buf (.clk_in(clk), .busy_in(busy), .col_vld_in(vld), .col_in(col),
    .step_out(step), .edit_out(edit), .p1_done_out(p1), .last_row_out(lastrow));

  // Storage word: digit j of address a is (a + j) mod 10, sign is the low address bit
  function automatic logic [43:0] word_of(input logic [15:0] a);
    logic [43:0] w;
    w = 44'h0;
    for (int j = 0; j < 10; j++) begin
      w[4*j +: 4] = 4'((a + j) % 10);
    end
    w[40] = a[0];
    if (a == bad_a) begin
      w[11:8] = 4'hc; // Not a decimal digit
    end
    return w;
  endfunction
  assign mdata = word_of(maddr);

  function automatic int rnd(input int n);
    return int'($unsigned($random(seed)) % n);
  endfunction

  function automatic logic [4:0] relays(input logic [3:0] c);
    case (c)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5: return 5'h1 << (c - 4'h1);
      4'h6: return 5'h0a;
      4'h7: return 5'h14;
      4'h9: return 5'h01;
      default: return 5'h00;
    endcase
  endfunction

  // Read log, send count and hang guard
  always @(posedge clk) begin
    cycles++;
    if (rd) reads.push_back(maddr);
    if (send) n_send++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Edit stream: nine digits then a merged sign, or ten digits then the sign alone, when mixed; else plain digits
  task automatic fill(input logic mix);
    mixed = mix;
    tail = mix && (rnd(2) == 1);
    for (int k = 0; k < 512; k++) i_buf.edits[k] = 2'h1;
    i_buf.edits[9] = tail ? 2'h3 : 2'h1;
    i_buf.edits[10] = (mix && !tail) ? 2'h2 : 2'h1;
  endtask

  task automatic run(input logic [7:0] op, input logic [3:0] sg, f, c, u, input logic [15:0] a,
                     input int ns, input logic [3:0] exp_al);
    logic [43:0] w;
    logic [3:0]  d;
    logic [1:0]  ez;
    eb = 16'(a + (sg[0] ? index : 16'h0));
    i_buf.n_steps = ns;
    i_buf.gap = 30 + rnd(20);
    i_buf.cols.delete();
    reads.delete();
    n_send = 0;
    instr <= '{sgn: sg, unit: u, spare: 4'h0, ctl: c, fmt: f, op: op, addr: a};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (FETCH + 8) @(posedge clk);
    if (exp_al != 4'h2) begin
      check("band", 16'((f >> 1) + 1), 16'(band));
      check("unit", 16'(u), 16'(unit));
      check("mode", 16'(op == 8'h62 ? f[0] : !f[0]), 16'(op == 8'h62 ? lock : sup));
      check("load kind", 16'(op == 8'h62), 16'(fl));
      if (op == 8'h61) check("relays", 16'(relays(c)), 16'(relay));
    end
    for (int t = 0; t < 30000 && done !== 1'b1 && alarm === 4'h0; t++) @(posedge clk);
    check("ended", 16'h1, 16'(done === 1'b1 || alarm !== 4'h0));
    while (i_buf.active) @(posedge clk);
    check("alarm", 16'(exp_al), 16'(alarm));
    if (exp_al != 4'h2) check("part two start", 16'(op == 8'h61), 16'(n_send));
    if (reads.size() > 0) check("first address", eb, reads[0]);
    w = word_of(eb);
    for (int j = 0; j < 11 && j < i_buf.cols.size() && exp_al == 4'h0; j++) begin
      d = (j == 10) ? w[43:40] : w[4*j +: 4];
      ez = w[40] ? 2'h1 : (f[0] ? 2'h2 : 2'h0);
      if (op == 8'h62) check("band digit", 16'(d & 4'h3), 16'(i_buf.cols[j].num));
      else if (j < 9 || (j == 9 && !tail) || (j == 10 && !mixed)) check("digit", 16'(d), 16'(i_buf.cols[j].num));
      else if (j == 9 || !tail) begin
        check("sign column", 16'({ez, !tail}), 16'({i_buf.cols[j].zone, i_buf.cols[j].blank}));
        if (tail) check("merged digit", 16'(d), 16'(i_buf.cols[j].num));
      end
    end
    if (alarm !== 4'h0) begin
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (2) @(posedge clk);
      check("alarm cleared", 16'h0, 16'(alarm));
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: every relay code, full transfers, then the address, unit and digit alarms
  initial begin
    seed = 32'h400ee2e5;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check("band after reset", 16'h1, 16'(band));
    for (int c = 0; c < 10; c++) begin
      fill(1'b1);
      run(8'h61, 4'(rnd(2)), 4'(rnd(10)), 4'(c), 4'(rnd(10)), 16'(100 + rnd(3000)), 14, 4'h0);
    end
    fill(1'b0);
    run(8'h61, 4'h1, 4'(rnd(10)), 4'h9, 4'h1, 16'h0007, 330, 4'h0);
    check("words read", 16'd29, 16'(reads.size()));
    check("columns sent", 16'd317, 16'(i_buf.cols.size()));
    run(8'h62, 4'h0, 4'(rnd(10)), 4'h0, 4'h4, 16'h0010, 330, 4'h0);
    check("words read", 16'd29, 16'(reads.size()));
    check("positions sent", 16'd315, 16'(i_buf.cols.size()));
    run(8'h61, 4'h0, 4'h1, 4'h3, 4'h2, 16'd4001, 14, 4'h1);
    check("columns", 16'h0, 16'(i_buf.cols.size()));
    run(8'h62, 4'h0, 4'h2, 4'h0, 4'h2, 16'd4001, 14, 4'h1);
    present <= 10'h37f;
    run(8'h61, 4'h0, 4'h2, 4'h1, 4'h7, 16'd50, 14, 4'h2);
    run(8'h62, 4'h0, 4'h3, 4'h0, 4'h7, 16'd50, 14, 4'h2);
    present <= 10'h3ff;
    bad_a <= 16'd300;
    run(8'h61, 4'h0, 4'h3, 4'h0, 4'h1, 16'd300, 14, 4'h4);
    check("columns before bad digit", 16'h2, 16'(i_buf.cols.size()));
    finish_test();
  end
endmodule
